/* rtl/sesc_pkg.sv */
// Constants, types and check-bit functions of the serial memory command slave.
// Assumes a single core clock of 25 MHz and a serial clock supplied by the master.
package sesc_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W  = 16;
  localparam int GRP_W   = ADDR_W - 2;
  localparam int ECC_W   = 6;
  localparam int CW_LAST = 38;

  // ---------------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
  localparam logic [7:0] OPC_STAT_RD   = 8'h05;
  localparam logic [7:0] OPC_STAT_WR   = 8'h01;
  localparam logic [7:0] OPC_MEM_RD    = 8'h03;
  localparam logic [7:0] OPC_MEM_WR    = 8'h02;

  // ---------------------------------------------------------------------------
  // Status byte layout and reset values
  // ---------------------------------------------------------------------------
  localparam int SR_LOCK    = 7;
  localparam int SR_PS_HI   = 3;
  localparam int SR_PS_LO   = 2;
  localparam int SR_WEL     = 1;
  localparam int SR_BUSY    = 0;
  localparam logic       LOCK_INIT = 1'b0;
  localparam logic [1:0] PS_INIT   = 2'b00;
  localparam logic [7:0] MEM_INIT  = 8'hff;

  // Protect-size settings
  localparam logic [1:0] PS_NONE    = 2'b00;
  localparam logic [1:0] PS_QUARTER = 2'b01;
  localparam logic [1:0] PS_HALF    = 2'b10;
  localparam logic [1:0] PS_TOP_Q   = 2'b11;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam real CLK_PERIOD_NS   = 40.0;
  localparam real WRITE_TIME_MS   = 5.0;
  localparam int  WRITE_CYC_DEF   = int'($floor(WRITE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    CMD_NONE  = 7'b0000001,
    CMD_SETL  = 7'b0000010,
    CMD_CLRL  = 7'b0000100,
    CMD_STRD  = 7'b0001000,
    CMD_STWR  = 7'b0010000,
    CMD_MEMRD = 7'b0100000,
    CMD_MEMWR = 7'b1000000
  } sesc_cmd_t;

  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,
    L_OPC  = 5'b00010,
    L_ADDR = 5'b00100,
    L_DATA = 5'b01000,
    L_STAT = 5'b10000
  } sesc_link_st_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'b01,
    C_BUSY = 2'b10
  } sesc_core_st_t;

  // Frame outcome handed from the serial side to the core side
  typedef struct packed {
    sesc_cmd_t          kind;
    logic               ok;
    logic               frame_tog;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        data;
    logic [3:0]         mask;
  } sesc_result_t;

  // ---------------------------------------------------------------------------
  // Single-error-correcting check bits over 32 data bits
  // ---------------------------------------------------------------------------
  function automatic logic [ECC_W-1:0] ecc_encode(input logic [31:0] d);
    logic [ECC_W-1:0] c;
    int               j;
    c = '0;
    j = 0;
    for (int p = 1; p <= CW_LAST; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (d[j])
          c = c ^ p[ECC_W-1:0];
        j++;
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] ecc_correct(input logic [31:0] d, input logic [ECC_W-1:0] e);
    logic [31:0]      r;
    logic [ECC_W-1:0] s;
    int               j;
    r = d;
    s = ecc_encode(d) ^ e;
    j = 0;
    for (int p = 1; p <= CW_LAST; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (p[ECC_W-1:0] == s)
          r[j] = ~r[j];
        j++;
      end
    end
    return r;
  endfunction

  localparam logic [ECC_W-1:0] ECC_INIT = ecc_encode({4{MEM_INIT}});

endpackage

/* rtl/sesc_spi_slave.sv */
// Serial-peripheral command slave with 64K x 8 check-bit protected storage.
// Assumes the master drives the serial clock, chip select and pause in mode 0 or 3,
// and never clocks while chip select is high or the core reset is held.
// Operation
// - Chip select high deselects; serial output floats.
// - After power-on a chip-select rise is needed before any instruction.
// - Input bits sampled on rising serial clock edges.
// - Output bits change only on falling serial clock edges.
// - Pause floats output, ignores clock and input, keeps transfer state.
// - Internal write finishes within 5.0 ms, then busy clears.
// - Six check bits per four-byte group; single-bit errors corrected on read.
// - Partial group writes rewrite the whole group with check bits.
// - Instruction starts after chip-select fall, one opcode byte MSB first.
// - Unknown opcode deselects until chip select rises and falls again.
// - Status read repeats the status byte, bit 7 first, while clocked.
// - Status write takes one data byte on clocks 9 to 16.
// - Memory read/write carry 16-bit address; read streams successive bytes.
// - Lock bit set and protect pin low: status bits read-only.
// - Protect-size bits select protected memory area, writable unless locked.
// - Latch set only by set-latch; clear latch refuses writes.
// - Latch clears at power-on, clear-latch, and end of internal write.
// - Busy bit is 1 only during an internal write.
// - Set-latch acts only when chip select rises after exactly 8 clocks.
// - Delivered memory reads FFh, nonvolatile status bits zero.
// - Setting 01 protects C000h-FFFFh, 10 protects 8000h-FFFFh.
// - Status bits 6 to 4 read zero and never change.
// - Memory read opcode refused while internal write runs.
`timescale 1ns/1ns
module sesc_spi_slave
  import sesc_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYC_DEF
)
(
  // Core clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Serial link
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic        i_hold_n,
  input  wire logic        i_wp_n,
  output logic             o_so,
  output logic             o_so_oe,
  // Observation
  output logic [7:0]       o_status
);

  localparam int CNT_W = $clog2(WRITE_CYC + 1);

  // ---------------------------------------------------------------------------
  // Storage and core status
  // ---------------------------------------------------------------------------
  logic [31:0]      mem_data [2**GRP_W];
  logic [ECC_W-1:0] mem_ecc  [2**GRP_W];
  logic             lock_reg;
  logic [1:0]       psize_reg;
  logic             wel_reg;
  sesc_core_st_t    core_reg;
  logic [CNT_W-1:0] wcnt_reg;
  logic             pend_mem_reg;
  logic [GRP_W-1:0] pend_grp_reg;
  logic [31:0]      pend_word_reg;
  logic [2:0]       pend_sr_reg;
  logic [7:0]       status;

  assign status   = {lock_reg, 3'b000, psize_reg, wel_reg, core_reg == C_BUSY};
  assign o_status = status;

  // ---------------------------------------------------------------------------
  // Serial side: frame state
  // ---------------------------------------------------------------------------
  sesc_link_st_t     state_reg;
  sesc_cmd_t         cmd_reg;
  logic [2:0]        cnt_reg;
  logic [1:0]        byte_reg;
  logic [6:0]        sh_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0]        in_byte;
  logic              byte_done;
  logic [7:0]        st_s1_reg;
  logic [7:0]        st_s2_reg;
  logic [7:0]        st_snap_reg;
  sesc_result_t      res_reg;
  logic              so_reg;
  logic              so_en_reg;
  logic [31:0]       rd_word;
  logic [7:0]        rd_byte;

  assign in_byte   = {sh_reg, i_si};
  assign byte_done = (cnt_reg == 3'h7);

  assign rd_word = ecc_correct(mem_data[addr_reg[ADDR_W-1:2]], mem_ecc[addr_reg[ADDR_W-1:2]]);
  assign rd_byte = rd_word[8*addr_reg[1:0] +: 8];

  always_ff @(posedge i_sck or negedge i_rstn or posedge i_cs_n)
  begin
    if (!i_rstn)
    begin
      state_reg <= L_IDLE;
      cmd_reg   <= CMD_NONE;
      cnt_reg   <= 3'h0;
      byte_reg  <= 2'h0;
      sh_reg    <= 7'h00;
      addr_reg  <= '0;
    end
    else if (i_cs_n)
    begin
      state_reg <= L_OPC;
      cmd_reg   <= CMD_NONE;
      cnt_reg   <= 3'h0;
      byte_reg  <= 2'h0;
      sh_reg    <= 7'h00;
      addr_reg  <= '0;
    end
    else if (i_hold_n)
    begin
      cnt_reg <= cnt_reg + 3'h1;
      sh_reg  <= in_byte[6:0];
      if (byte_done && byte_reg != 2'h3)
        byte_reg <= byte_reg + 2'h1;
      unique case (state_reg)
        L_OPC:
        begin
          if (byte_done)
          begin
            unique case (in_byte)
              OPC_SET_LATCH:
              begin
                cmd_reg   <= CMD_SETL;
                state_reg <= L_IDLE;
              end
              OPC_CLR_LATCH:
              begin
                cmd_reg   <= CMD_CLRL;
                state_reg <= L_IDLE;
              end
              OPC_STAT_RD:
              begin
                cmd_reg   <= CMD_STRD;
                state_reg <= L_STAT;
              end
              OPC_STAT_WR:
              begin
                cmd_reg   <= CMD_STWR;
                state_reg <= L_DATA;
              end
              OPC_MEM_RD:
              begin
                cmd_reg   <= CMD_MEMRD;
                state_reg <= st_s2_reg[SR_BUSY] ? L_IDLE : L_ADDR;
              end
              OPC_MEM_WR:
              begin
                cmd_reg   <= CMD_MEMWR;
                state_reg <= L_ADDR;
              end
              default:
              begin
                cmd_reg   <= CMD_NONE;
                state_reg <= L_IDLE;
              end
            endcase
          end
        end
        L_ADDR:
        begin
          if (byte_done && byte_reg == 2'h1)
            addr_reg[ADDR_W-1:8] <= in_byte;
          else if (byte_done)
          begin
            addr_reg[7:0] <= in_byte;
            state_reg     <= L_DATA;
          end
        end
        L_DATA:
        begin
          if (byte_done && cmd_reg == CMD_MEMRD)
            addr_reg <= addr_reg + ADDR_W'(1);
          else if (byte_done && cmd_reg == CMD_MEMWR)
            addr_reg[1:0] <= addr_reg[1:0] + 2'h1;
          else if (byte_done)
            state_reg <= L_IDLE;
        end
        L_STAT,
        L_IDLE:
        begin
          state_reg <= state_reg;
        end
        default:
        begin
          state_reg <= L_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Serial side: status copy and frame outcome
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sck or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_s1_reg   <= 8'h00;
      st_s2_reg   <= 8'h00;
      st_snap_reg <= 8'h00;
    end
    else
    begin
      st_s1_reg <= status;
      st_s2_reg <= st_s1_reg;
      if (byte_done && i_hold_n && !i_cs_n)
        st_snap_reg <= st_s2_reg;
    end
  end

  // Outcome stays put after chip select rises; the core reads it then
  always_ff @(posedge i_sck or negedge i_rstn)
  begin
    if (!i_rstn)
      res_reg <= '{kind: CMD_NONE, default: '0};
    else if (i_hold_n && !i_cs_n)
    begin
      if (cnt_reg == 3'h0 && byte_reg == 2'h0)
      begin
        res_reg.frame_tog <= ~res_reg.frame_tog;
        res_reg.mask      <= 4'h0;
        res_reg.kind      <= CMD_NONE;
      end
      res_reg.ok <= 1'b0;
      if (byte_done)
      begin
        unique case (state_reg)
          L_OPC:
          begin
            if (in_byte == OPC_SET_LATCH || in_byte == OPC_CLR_LATCH)
            begin
              res_reg.ok   <= 1'b1;
              res_reg.kind <= (in_byte == OPC_SET_LATCH) ? CMD_SETL : CMD_CLRL;
            end
          end
          L_ADDR:
          begin
            if (byte_reg != 2'h1)
              res_reg.addr <= {addr_reg[ADDR_W-1:8], in_byte};
          end
          L_DATA:
          begin
            if (cmd_reg == CMD_STWR)
            begin
              res_reg.ok        <= 1'b1;
              res_reg.kind      <= CMD_STWR;
              res_reg.data[7:0] <= in_byte;
            end
            else if (cmd_reg == CMD_MEMWR)
            begin
              res_reg.ok                        <= 1'b1;
              res_reg.kind                      <= CMD_MEMWR;
              res_reg.data[8*addr_reg[1:0] +: 8] <= in_byte;
              res_reg.mask[addr_reg[1:0]]       <= 1'b1;
            end
          end
          L_STAT,
          L_IDLE:
          begin
            res_reg.ok <= 1'b0;
          end
          default:
          begin
            res_reg.ok <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------------------
  // falling edge update
  always_ff @(negedge i_sck or negedge i_rstn or posedge i_cs_n)
  begin
    if (!i_rstn)
    begin
      so_reg    <= 1'b0;
      so_en_reg <= 1'b0;
    end
    else if (i_cs_n)
    begin
      so_reg    <= 1'b0;
      so_en_reg <= 1'b0;
    end
    else if (i_hold_n)
    begin
      if (state_reg == L_STAT)
      begin
        so_reg    <= st_snap_reg[~cnt_reg];
        so_en_reg <= 1'b1;
      end
      else if (state_reg == L_DATA && cmd_reg == CMD_MEMRD)
      begin
        so_reg    <= rd_byte[~cnt_reg];
        so_en_reg <= 1'b1;
      end
      else
        so_en_reg <= 1'b0;
    end
  end

  assign o_so    = so_reg;
  assign o_so_oe = so_en_reg & ~i_cs_n & i_hold_n;

  // ---------------------------------------------------------------------------
  // Core side: pin synchronisers
  // ---------------------------------------------------------------------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic seen_tog_reg;
  logic cs_rise;
  logic hw_lock;
  logic wr_protected;
  logic exec;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
    end
    else
    begin
      cs_s1_reg <= i_cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      wp_s1_reg <= i_wp_n;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  assign cs_rise = cs_s2_reg & ~cs_s3_reg;
  assign exec    = cs_rise && (res_reg.frame_tog != seen_tog_reg) && res_reg.ok;
  assign hw_lock = lock_reg & ~wp_s2_reg;

  always_comb
  begin
    unique case (psize_reg)
      PS_NONE:    wr_protected = 1'b0;
      PS_QUARTER: wr_protected = (res_reg.addr[ADDR_W-1:ADDR_W-2] == 2'b11);
      PS_HALF:    wr_protected = res_reg.addr[ADDR_W-1];
      PS_TOP_Q:   wr_protected = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Core side: read-modify-write merge
  // ---------------------------------------------------------------------------
  logic [31:0] old_word;
  logic [31:0] merged;

  always_comb
  begin
    old_word = ecc_correct(mem_data[res_reg.addr[ADDR_W-1:2]], mem_ecc[res_reg.addr[ADDR_W-1:2]]);
    merged   = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (res_reg.mask[b])
        merged[8*b +: 8] = res_reg.data[8*b +: 8];
    end
  end

  // ---------------------------------------------------------------------------
  // Core side: command execution and write cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      lock_reg      <= LOCK_INIT;
      psize_reg     <= PS_INIT;
      wel_reg       <= 1'b0;
      core_reg      <= C_IDLE;
      wcnt_reg      <= '0;
      pend_mem_reg  <= 1'b0;
      pend_grp_reg  <= '0;
      pend_word_reg <= '0;
      pend_sr_reg   <= 3'h0;
      seen_tog_reg  <= 1'b0;
    end
    else
    begin
      if (cs_rise)
        seen_tog_reg <= res_reg.frame_tog;
      if (core_reg == C_BUSY)
      begin
        if (wcnt_reg == '0)
        begin
          core_reg <= C_IDLE;
          wel_reg  <= 1'b0;
          if (!pend_mem_reg)
          begin
            lock_reg  <= pend_sr_reg[2];
            psize_reg <= pend_sr_reg[1:0];
          end
        end
        else
          wcnt_reg <= wcnt_reg - CNT_W'(1);
      end
      if (exec)
      begin
        unique case (res_reg.kind)
          CMD_SETL:
            wel_reg <= 1'b1;
          CMD_CLRL:
            wel_reg <= 1'b0;
          CMD_STWR:
          begin
            if (wel_reg && core_reg == C_IDLE && !hw_lock)
            begin
              core_reg     <= C_BUSY;
              wcnt_reg     <= CNT_W'(WRITE_CYC - 1);
              pend_mem_reg <= 1'b0;
              pend_sr_reg  <= {res_reg.data[SR_LOCK], res_reg.data[SR_PS_HI], res_reg.data[SR_PS_LO]};
            end
          end
          CMD_MEMWR:
          begin
            if (wel_reg && core_reg == C_IDLE && !wr_protected)
            begin
              core_reg      <= C_BUSY;
              wcnt_reg      <= CNT_W'(WRITE_CYC - 1);
              pend_mem_reg  <= 1'b1;
              pend_grp_reg  <= res_reg.addr[ADDR_W-1:2];
              pend_word_reg <= merged;
            end
          end
          CMD_NONE,
          CMD_STRD,
          CMD_MEMRD:
            wel_reg <= wel_reg;
          default:
            wel_reg <= wel_reg;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Storage array
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      for (int g = 0; g < 2**GRP_W; g++)
      begin
        mem_data[g] <= {4{MEM_INIT}};
        mem_ecc[g]  <= ECC_INIT;
      end
    end
    else if (core_reg == C_BUSY && wcnt_reg == '0 && pend_mem_reg)
    begin
      mem_data[pend_grp_reg] <= pend_word_reg;
      mem_ecc[pend_grp_reg]  <= ecc_encode(pend_word_reg);
    end
  end

endmodule

/* test/sesc_spi_slave_monitor.sv */
// Port checker of the serial memory command slave.
// Assumes core clock i_clk and synchronous active-low reset i_rstn.
`timescale 1ns/1ns
module sesc_spi_slave_monitor
  import sesc_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYC_DEF
)
(
  // Core
  input wire logic       i_clk,
  input wire logic       i_rstn,
  // Serial link and status
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       i_si,
  input wire logic       i_hold_n,
  input wire logic       i_wp_n,
  input wire logic       o_so,
  input wire logic       o_so_oe,
  input wire logic [7:0] o_status
);
  localparam int BMAX = int'(WRITE_CYC) + 2;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_busy_on;
    $rose(o_status[0]);
  endsequence
  sequence s_locked;
    (o_status[7] && !i_wp_n) [*4];
  endsequence
  property p_cs_float; i_cs_n |-> !o_so_oe; endproperty
  property p_hold_float; !i_hold_n |-> !o_so_oe; endproperty
  property p_rsvd_zero; o_status[6:4] == 3'h0; endproperty
  property p_busy_hold; s_busy_on |-> o_status[0] [*8]; endproperty
  property p_busy_end; s_busy_on |-> ##[1:BMAX] !o_status[0]; endproperty
  property p_busy_wel; s_busy_on |-> $past(o_status[1]); endproperty
  property p_end_wel; $fell(o_status[0]) |-> !o_status[1]; endproperty
  property p_lock; s_locked |-> $stable(o_status[7:2]); endproperty
  property p_init; $rose(i_rstn) |-> o_status == 8'h00; endproperty
  a_cs_float: assert property (p_cs_float) else $error("so driven while deselected");
  a_hold_float: assert property (p_hold_float) else $error("so driven while paused");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bits set");
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  a_busy_end: assert property (p_busy_end) else $error("busy too long");
  a_busy_wel: assert property (p_busy_wel) else $error("write without latch");
  a_end_wel: assert property (p_end_wel) else $error("latch kept after write");
  a_lock: assert property (p_lock) else $error("locked status changed");
  a_init: assert property (p_init) else $error("status not clear after reset");
endmodule

bind sesc_spi_slave sesc_spi_slave_monitor #(.WRITE_CYC(WRITE_CYC)) u_mon (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_status(o_status));

/* test/sesc_spi_master.sv */
// Mode 0 serial master model, 48 ns clock that runs only within frames.
// Assumes its caller spaces frames; each frame ends with 200 ns deselect.
`timescale 1ns/1ns
module sesc_spi_master (
  // Link outputs
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n,
  // Link inputs
  input wire logic  i_so,
  input wire logic  i_so_oe
);
  logic oe_seen;
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    oe_seen = 1'b0;
  end
  task automatic xfer(input logic [63:0] tx, input int n, input int hp, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    #7;
    o_cs_n = 1'b0;
    #24;
    for (int i = 0; i < n; i++)
    begin
      o_si = tx[63-i];
      #24 o_sck = 1'b1;
      rx = {rx[62:0], i_so_oe ? i_so : ~i_so};
      oe_seen = oe_seen | i_so_oe;
      #24 o_sck = 1'b0;
      if (i == hp)
      begin
        #4 o_hold_n = 1'b0;
        o_si = ~o_si;
        #20 o_sck = 1'b1;
        #24 o_sck = 1'b0;
        #20 o_hold_n = 1'b1;
      end
    end
    #24 o_cs_n = 1'b1;
    o_si = ~o_si;
    #200;
  endtask
endmodule

/* test/sesc_spi_slave_tb.sv */
// Self-checking bench of the serial memory command slave.
// Assumes the master model and the bound port checker.
`timescale 1ns/1ns
module sesc_spi_slave_tb;
  import sesc_pkg::*;
  localparam int WC = 60;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_wp_n = 1'b1;
  logic        sck, cs_n, si, hold_n, so, so_oe;
  logic [7:0]  status;
  logic [63:0] rx;
  logic [7:0]  st = 8'h00;
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] adr [4];
  logic [31:0] dw;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #20 i_clk = ~i_clk;
  sesc_spi_slave #(.WRITE_CYC(WC)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .o_status(status));
  sesc_spi_master u_mst (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so), .i_so_oe(so_oe));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] rd(input logic [15:0] ad);
    return mem.exists(ad) ? mem[ad] : MEM_INIT;
  endfunction
  function automatic bit prot(input logic [15:0] ad);
    case (st[3:2])
      PS_NONE: return 1'b0;
      PS_QUARTER: return ad >= 16'hc000;
      PS_HALF: return ad >= 16'h8000;
      default: return 1'b1;
    endcase
  endfunction
  task automatic op(input logic [7:0] oc, input logic [23:0] x, input int n, input int hp = -1);
    u_mst.xfer({oc, x, 32'h0}, n, hp, rx);
  endtask
  task automatic wt();
    for (int k = 0; k < WC + 20 && status[0] !== 1'b0; k++)
      @(posedge i_clk);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic sts(input int hp);
    op(OPC_STAT_RD, 24'h0, 24, hp);
    chk("status_read", {st, st}, rx[15:0]);
    chk("status", st, status);
  endtask
  task automatic ws(input logic [7:0] v);
    op(OPC_SET_LATCH, 24'h0, 8);
    op(OPC_STAT_WR, {v, 16'h0}, 16);
    st[1] = 1'b1;
    if (!(st[7] && !i_wp_n))
    begin
      chk("busy", 1, status[0]);
      wt();
      st = v & 8'h8c;
    end
    chk("status", st, status);
  endtask
  task automatic wm(input logic [15:0] ad, input logic [7:0] dv);
    op(OPC_SET_LATCH, 24'h0, 8);
    st[1] = 1'b1;
    op(OPC_MEM_WR, {ad, dv}, 32);
    if (!prot(ad))
    begin
      mem[ad] = dv;
      op(OPC_MEM_RD, {ad, 8'h0}, 32);
      chk("read_while_busy_oe", 0, u_mst.oe_seen);
      wt();
      st[1] = 1'b0;
    end
    chk("status", st, status);
    op(OPC_MEM_RD, {ad, 8'h0}, 40);
    chk("read_data", {rd(ad), rd(ad + 16'h1)}, rx[15:0]);
  endtask
  initial
  begin
    void'($urandom(65547));
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_clk);
    op(8'h00, 24'h0, 0);
    sts(-1);
    $display("test 1 done");
    op(OPC_MEM_WR, 24'h1234a5, 32);
    chk("status", st, status);
    op(OPC_SET_LATCH, 24'h0, 9);
    chk("status", st, status);
    op(OPC_SET_LATCH, 24'h0, 8);
    st[1] = 1'b1;
    chk("status", st, status);
    op(OPC_CLR_LATCH, 24'h0, 8);
    st[1] = 1'b0;
    chk("status", st, status);
    $display("test 2 done");
    for (int ps = 0; ps < 4; ps++)
    begin
      ws({1'b0, 3'($urandom), 2'(ps), 2'($urandom)});
      adr = '{16'($urandom), 16'h7fff, 16'hc000, 16'hffff};
      foreach (adr[j])
        wm(adr[j], 8'($urandom));
    end
    $display("test 3 done");
    ws(8'h88);
    @(posedge i_clk);
    i_wp_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    ws(8'h04);
    @(posedge i_clk);
    i_wp_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    ws(8'h00);
    op(OPC_SET_LATCH, 24'h0, 8);
    dw = $urandom;
    adr[0] = 16'($urandom) & 16'hfffc;
    u_mst.xfer({OPC_MEM_WR, adr[0], dw, 8'h00}, 56, -1, rx);
    for (int k = 0; k < 4; k++)
      mem[adr[0] + 16'(k)] = dw[31-8*k -: 8];
    wt();
    chk("status", st, status);
    op(OPC_MEM_RD, {adr[0], 8'h0}, 40);
    chk("group_read", {rd(adr[0]), rd(adr[0] + 16'h1)}, rx[15:0]);
    $display("test 4 done");
    op(8'hff, 24'h050000, 32);
    chk("bad_opcode_oe", 0, u_mst.oe_seen);
    op(OPC_SET_LATCH, 24'h0, 8);
    st[1] = 1'b1;
    sts(12);
    $display("test 5 done");
    tally_and_finish();
  end
endmodule
